// ### logic/swd_top.sv
// Supply supervisor: channel resets, windowed watchdog, start-up gating.
// Contract
// (R01) Resets held low while enabled and supplied
// (R02) HV feedback good starts timer, releases
// (R03) LV feedback good starts timer, releases
// (R04) Both resets released starts start delay
// (R05) No kick checking during start delay
// (R06) Only falling kick edges count
// (R07) Bad kick spacing asserts fault, starts timer
// (R08) Fault timer end releases, reruns delay
// (R09) Reset and fault outputs are open drain
// (R10) LV good needs enable and feedback
// (R11) Power good low when both regulate
// (R12) LV switching needs supply, enable, HV
// (R13) LV soft-start discharged on LV faults
// (R14) Main supply fault discharges HV soft-start
// (R15) Overvoltage inhibits switching in both channels
// (R16) External clock used only after HV good
// (R17) Fault output only while watchdog enabled
// (R18) Reset timeout nominally 9.5 ms
// (R19) Start delay nominally 16 ms
// (R20) Kick window 2 ms to 32 ms
// (R21) Periods are programmable cycle counts
// (R22) First interval from supervision start
// (R23) Comparator inputs synchronised before use
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ns
module swd_top
    import swd_pkg::*;
#(
    parameter int          CNT_W   = 32,
    parameter int unsigned RST_CYC = CYC_RST,
    parameter int unsigned DLY_CYC = CYC_DLY,
    parameter int unsigned WDL_CYC = CYC_WDL,
    parameter int unsigned WDU_CYC = CYC_WDU
) (
    // Clock and reset.
    input  wire logic              clk,
    input  wire logic              rst_n,
    // APB slave.
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Comparator results and control pins.
    input  wire logic              chip_enable_lockout,
    input  wire logic              main_supply_ok,
    input  wire logic              overvoltage_lockout,
    input  wire logic              hv_feedback,
    input  wire logic              lv_feedback,
    input  wire logic              lv_supply_above_start,
    input  wire logic              lv_supply_above_stop,
    input  wire logic              lv_channel_enable,
    input  wire logic              watchdog_enable,
    input  wire logic              watchdog_kick,
    input  wire logic              hv_softstart_low,
    input  wire logic              lv_softstart_low,
    input  wire logic              external_clock_in,
    // Open-drain reset, fault and power good pins.
    input  wire logic              hv_reset_n_in,
    output logic                   hv_reset_n_o,
    output logic                   hv_reset_n_oe,
    input  wire logic              lv_reset_n_in,
    output logic                   lv_reset_n_o,
    output logic                   lv_reset_n_oe,
    input  wire logic              watchdog_fault_n_in,
    output logic                   watchdog_fault_n_o,
    output logic                   watchdog_fault_n_oe,
    output logic                   power_good_n_o,
    output logic                   power_good_n_oe,
    // Regulator control.
    output logic                   hv_switch_enable,
    output logic                   lv_switch_enable,
    output logic                   hv_softstart_discharge,
    output logic                   lv_softstart_discharge,
    output logic                   osc_restart
);

    // True once a timer counting from zero has run for the period.
    function automatic logic timer_done(input logic [CNT_W-1:0] cnt,
                                        input logic [CNT_W-1:0] per);
        timer_done = ({1'b0, cnt} + {{CNT_W{1'b0}}, 1'b1}) >= {1'b0, per};
    endfunction

    // APB address decode.
    function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                     input logic [7:0]        off);
        addr_is = (a == off);
    endfunction

    // Input synchronisation.
    logic [N_IN-1:0] raw_in;
    logic [N_IN-1:0] syn;

    assign raw_in = {watchdog_fault_n_in, lv_reset_n_in, hv_reset_n_in,
                     external_clock_in, lv_softstart_low, hv_softstart_low,
                     watchdog_kick, watchdog_enable, lv_channel_enable,
                     lv_supply_above_stop, lv_supply_above_start,
                     lv_feedback, hv_feedback, overvoltage_lockout,
                     main_supply_ok, chip_enable_lockout};

    swd_sync #(
        .WIDTH (N_IN)
    ) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (raw_in),
        .q     (syn)
    ); // R23

    wire chip_ok  = syn[IN_CHIP_EN] & syn[IN_MAIN_OK];
    wire main_ov  = syn[IN_MAIN_OV];
    wire hv_good  = syn[IN_HV_FB];
    wire lv_good  = syn[IN_LV_EN] & syn[IN_LV_FB]; // R10
    wire wd_en    = syn[IN_WD_EN];

    // Edge detection on the filtered kick and external clock.
    logic kick_prev_q;
    logic ext_prev_q;
    wire  kick_fall = kick_prev_q & ~syn[IN_KICK]; // R06
    wire  ext_rise  = ~ext_prev_q & syn[IN_EXT_CLK];

    // Programmable periods.
    logic [CNT_W-1:0] rst_per_q;
    logic [CNT_W-1:0] dly_per_q;
    logic [CNT_W-1:0] wdl_per_q;
    logic [CNT_W-1:0] wdu_per_q;

    // APB register access; the slave never inserts wait states.
    wire sel_rst  = addr_is(paddr, OFF_RST_PER);
    wire sel_dly  = addr_is(paddr, OFF_DLY_PER);
    wire sel_wdl  = addr_is(paddr, OFF_WDL_PER);
    wire sel_wdu  = addr_is(paddr, OFF_WDU_PER);
    wire sel_st   = addr_is(paddr, OFF_STATUS);
    wire addr_hit = sel_rst | sel_dly | sel_wdl | sel_wdu | sel_st;
    wire wr_stb   = psel & penable & pwrite & addr_hit;

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_hit;

    // Channel reset timers, index 0 is the high-voltage channel.
    logic [1:0]       chan_fb;
    logic [CNT_W-1:0] rst_cnt_q [2];
    logic [1:0]       rst_rel_q;
    logic [1:0]       rst_oe_q;

    assign chan_fb = {syn[IN_LV_FB], hv_good};

    for (genvar c = 0; c < 2; c++) begin : g_chan
        wire good = chip_ok & chan_fb[c];
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                rst_cnt_q[c] <= '0;
                rst_rel_q[c] <= 1'b0;
            end else if (!good) begin
                rst_cnt_q[c] <= '0;
                rst_rel_q[c] <= 1'b0;
            end else if (!rst_rel_q[c]) begin
                rst_cnt_q[c] <= rst_cnt_q[c] + 1'b1;
                rst_rel_q[c] <= timer_done(rst_cnt_q[c], rst_per_q);
            end
        end // R02 R03 R18
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                rst_oe_q[c] <= 1'b0;
            end else begin
                rst_oe_q[c] <= chip_ok & ~(good & rst_rel_q[c]); // R01
            end
        end
    end

    wire both_rel = rst_rel_q[0] & rst_rel_q[1];

    // Watchdog sequencer.
    swd_wd_state_t    wd_state_q;
    swd_wd_state_t    wd_state_d;
    logic [CNT_W-1:0] wd_cnt_q;
    logic [CNT_W-1:0] wd_cnt_d;

    wire too_early = ~timer_done(wd_cnt_q, wdl_per_q); // R20
    wire too_late  = timer_done(wd_cnt_q, wdu_per_q); // R20

    always_comb begin
        wd_state_d = wd_state_q;
        wd_cnt_d   = wd_cnt_q + 1'b1;
        case (wd_state_q)
            WD_IDLE: begin
                wd_cnt_d = '0;
                if (both_rel) begin
                    wd_state_d = WD_DELAY; // R04
                end
            end
            WD_DELAY: begin
                if (timer_done(wd_cnt_q, dly_per_q)) begin
                    wd_state_d = WD_WATCH; // R05 R19
                    wd_cnt_d   = '0; // R22
                end
            end
            WD_WATCH: begin
                if (!wd_en) begin
                    wd_cnt_d = '0; // R17
                end else if (kick_fall) begin
                    wd_cnt_d = '0; // R22
                    if (too_early) begin
                        wd_state_d = WD_FAULT; // R07
                    end
                end else if (too_late) begin
                    wd_state_d = WD_FAULT; // R07
                    wd_cnt_d   = '0;
                end
            end
            WD_FAULT: begin
                if (timer_done(wd_cnt_q, rst_per_q)) begin
                    wd_state_d = WD_DELAY; // R08
                    wd_cnt_d   = '0;
                end
            end
            default: begin
                wd_state_d = WD_IDLE;
                wd_cnt_d   = '0;
            end
        endcase
        if (!both_rel) begin
            wd_state_d = WD_IDLE;
            wd_cnt_d   = '0;
        end
    end

    // Soft-start discharge latches; a new fault wins over the clear.
    wire hv_ss_set = main_ov | ~syn[IN_MAIN_OK];
    wire lv_ss_set = ~syn[IN_LV_EN] | ~syn[IN_LV_2V2] | ~hv_good;
    logic hv_ss_q;
    logic lv_ss_q;
    logic wdf_oe_q;
    logic pg_oe_q;
    logic hv_sw_q;
    logic lv_sw_q;
    logic osc_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wd_state_q  <= WD_IDLE;
            wd_cnt_q    <= '0;
            kick_prev_q <= 1'b0;
            ext_prev_q  <= 1'b0;
        end else begin
            wd_state_q  <= wd_state_d;
            wd_cnt_q    <= wd_cnt_d;
            kick_prev_q <= syn[IN_KICK];
            ext_prev_q  <= syn[IN_EXT_CLK];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hv_ss_q <= 1'b0;
            lv_ss_q <= 1'b0;
        end else begin
            hv_ss_q <= hv_ss_set | (hv_ss_q & ~syn[IN_HV_SSLOW]); // R14
            lv_ss_q <= lv_ss_set | (lv_ss_q & ~syn[IN_LV_SSLOW]); // R13
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wdf_oe_q <= 1'b0;
            pg_oe_q  <= 1'b0;
            hv_sw_q  <= 1'b0;
            lv_sw_q  <= 1'b0;
            osc_q    <= 1'b0;
        end else begin
            wdf_oe_q <= (wd_state_q == WD_FAULT) & wd_en; // R07 R17
            pg_oe_q  <= hv_good & lv_good; // R11
            hv_sw_q  <= chip_ok & ~main_ov; // R15
            lv_sw_q  <= chip_ok & ~main_ov & syn[IN_LV_2V3]
                        & syn[IN_LV_EN] & hv_good; // R12 R15
            osc_q    <= ext_rise & hv_good; // R16
        end
    end

    // Period registers and read data.
    logic [31:0] status;
    logic [31:0] rd_mux;

    always_comb begin
        status                                = '0;
        status[ST_HV_REL]                     = rst_rel_q[0];
        status[ST_LV_REL]                     = rst_rel_q[1];
        status[ST_WD_FAULT]                   = wdf_oe_q;
        status[ST_WD_STATE +: 2]              = wd_state_q;
        status[ST_POWER_GOOD_N]                      = pg_oe_q;
        status[ST_HV_SW]                      = hv_sw_q;
        status[ST_LV_SW]                      = lv_sw_q;
        status[ST_HV_SS_DIS]                  = hv_ss_q;
        status[ST_LV_SS_DIS]                  = lv_ss_q;
        status[ST_PINS +: 3]                  = syn[IN_PIN_WDF:IN_PIN_HV];
    end

    assign rd_mux = sel_rst ? 32'(rst_per_q) :
                    sel_dly ? 32'(dly_per_q) :
                    sel_wdl ? 32'(wdl_per_q) :
                    sel_wdu ? 32'(wdu_per_q) :
                    sel_st  ? status         : 32'h0000_0000;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_per_q <= CNT_W'(RST_CYC);
            dly_per_q <= CNT_W'(DLY_CYC);
            wdl_per_q <= CNT_W'(WDL_CYC);
            wdu_per_q <= CNT_W'(WDU_CYC);
            prdata    <= 32'h0000_0000;
        end else begin
            if (wr_stb && sel_rst) rst_per_q <= CNT_W'(pwdata); // R21
            if (wr_stb && sel_dly) dly_per_q <= CNT_W'(pwdata); // R21
            if (wr_stb && sel_wdl) wdl_per_q <= CNT_W'(pwdata); // R21
            if (wr_stb && sel_wdu) wdu_per_q <= CNT_W'(pwdata); // R21
            if (psel && !penable && !pwrite) prdata <= rd_mux;
        end
    end

    // Open-drain pins only ever pull low; the board supplies the high.
    assign hv_reset_n_o           = 1'b0; // R09
    assign hv_reset_n_oe          = rst_oe_q[0];
    assign lv_reset_n_o           = 1'b0; // R09
    assign lv_reset_n_oe          = rst_oe_q[1];
    assign watchdog_fault_n_o     = 1'b0; // R09
    assign watchdog_fault_n_oe    = wdf_oe_q;
    assign power_good_n_o         = 1'b0;
    assign power_good_n_oe        = pg_oe_q;
    assign hv_switch_enable       = hv_sw_q;
    assign lv_switch_enable       = lv_sw_q;
    assign hv_softstart_discharge = hv_ss_q;
    assign lv_softstart_discharge = lv_ss_q;
    assign osc_restart            = osc_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_early_kick;
        wd_state_q == WD_WATCH && wd_en && both_rel && kick_fall
            && too_early;
    endsequence

    sequence s_fault_done;
        wd_state_q == WD_FAULT && both_rel
            && timer_done(wd_cnt_q, rst_per_q);
    endsequence

    a_reset_held_low: assert property ( // R01
        chip_ok && !rst_rel_q[0] |=> hv_reset_n_oe)
        else $error("hv reset not driven low while unreleased");
    a_hv_release_time: assert property ( // R02
        $rose(rst_rel_q[0]) |-> $past(chan_fb[0])
            && $past(rst_cnt_q[0]) + 1 >= $past(rst_per_q))
        else $error("hv reset released early");
    a_lv_release_time: assert property ( // R03
        $rose(rst_rel_q[1]) |-> $past(chan_fb[1])
            && $past(rst_cnt_q[1]) + 1 >= $past(rst_per_q))
        else $error("lv reset released early");
    a_delay_start: assert property ( // R04
        wd_state_q == WD_IDLE && both_rel |=> wd_state_q == WD_DELAY)
        else $error("start delay did not begin");
    a_no_check_delay: assert property ( // R05
        wd_state_q == WD_DELAY |=> wd_state_q != WD_FAULT)
        else $error("fault raised during start delay");
    a_rise_ignored: assert property ( // R06
        wd_state_q == WD_WATCH && both_rel && !kick_fall && !too_late
            |=> wd_state_q == WD_WATCH)
        else $error("watch left without falling kick or timeout");
    a_early_kick: assert property ( // R07
        s_early_kick ##1 (wd_en && both_rel) |=> watchdog_fault_n_oe)
        else $error("early kick did not assert fault");
    a_fault_rerun: assert property ( // R08
        s_fault_done |=> wd_state_q == WD_DELAY ##1 !watchdog_fault_n_oe)
        else $error("fault end did not rerun delay");
    a_fault_gated: assert property ( // R17
        !wd_en |=> !watchdog_fault_n_oe)
        else $error("fault asserted while watchdog disabled");
    a_power_good: assert property ( // R11
        power_good_n_oe == $past(hv_good && lv_good))
        else $error("power good mismatch");
    a_overvoltage_lockout_inhibit: assert property ( // R15
        main_ov |=> !hv_switch_enable && !lv_switch_enable)
        else $error("switching during overvoltage");
    a_hv_ss_latch: assert property ( // R14
        hv_ss_set |=> hv_softstart_discharge)
        else $error("hv soft-start not discharged");
    a_lv_switch: assert property ( // R12
        lv_switch_enable |-> $past(syn[IN_LV_2V3] && hv_good))
        else $error("lv switching without supply or hv good");
    a_sync_gated: assert property ( // R16
        osc_restart |-> $past(hv_good))
        else $error("external clock used before hv good");
endmodule

// ### logic/swd_pkg.sv
// Shared constants for the supply supervisor, reset and watchdog block.
package swd_pkg;

    // Device clock and nominal timer periods in microseconds.
    localparam int CLK_MHZ   = 50;
    localparam int T_RST_US  = 9500;
    localparam int T_DLY_US  = 16000;
    localparam int T_WDL_US  = 2000;
    localparam int T_WDU_US  = 32000;

    // Periods in device clock cycles; all divide exactly at 50 MHz.
    localparam int CYC_RST   = T_RST_US * CLK_MHZ;
    localparam int CYC_DLY   = T_DLY_US * CLK_MHZ;
    localparam int CYC_WDL   = T_WDL_US * CLK_MHZ;
    localparam int CYC_WDU   = T_WDU_US * CLK_MHZ;

    // Register map, byte addresses on the APB port.
    localparam int          ADDR_W      = 8;
    localparam logic [7:0]  OFF_RST_PER = 8'h00;
    localparam logic [7:0]  OFF_DLY_PER = 8'h04;
    localparam logic [7:0]  OFF_WDL_PER = 8'h08;
    localparam logic [7:0]  OFF_WDU_PER = 8'h0C;
    localparam logic [7:0]  OFF_STATUS  = 8'h10;

    // Status register bit positions.
    localparam int ST_HV_REL    = 0;
    localparam int ST_LV_REL    = 1;
    localparam int ST_WD_FAULT  = 2;
    localparam int ST_WD_STATE  = 3;
    localparam int ST_POWER_GOOD_N     = 5;
    localparam int ST_HV_SW     = 6;
    localparam int ST_LV_SW     = 7;
    localparam int ST_HV_SS_DIS = 8;
    localparam int ST_LV_SS_DIS = 9;
    localparam int ST_PINS      = 10;

    // Positions of the comparator and pin inputs in the synchroniser.
    localparam int IN_CHIP_EN  = 0;
    localparam int IN_MAIN_OK  = 1;
    localparam int IN_MAIN_OV  = 2;
    localparam int IN_HV_FB    = 3;
    localparam int IN_LV_FB    = 4;
    localparam int IN_LV_2V3   = 5;
    localparam int IN_LV_2V2   = 6;
    localparam int IN_LV_EN    = 7;
    localparam int IN_WD_EN    = 8;
    localparam int IN_KICK     = 9;
    localparam int IN_HV_SSLOW = 10;
    localparam int IN_LV_SSLOW = 11;
    localparam int IN_EXT_CLK  = 12;
    localparam int IN_PIN_HV   = 13;
    localparam int IN_PIN_LV   = 14;
    localparam int IN_PIN_WDF  = 15;
    localparam int N_IN        = 16;

    // Watchdog sequencer, Gray coded along idle, delay, watch, fault.
    typedef enum logic [1:0] {
        WD_IDLE  = 2'h0,
        WD_DELAY = 2'h1,
        WD_WATCH = 2'h3,
        WD_FAULT = 2'h2
    } swd_wd_state_t;

endpackage

// ### logic/swd_sync.sv
// Three-stage input synchroniser with two-stage agreement filter.
`timescale 1ns/1ns
module swd_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Asynchronous inputs and their filtered copies.
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A change is taken only once stages two and three agree.
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                q[i] <= 1'b0;
            end else if (s2_q[i] == s3_q[i]) begin
                q[i] <= s3_q[i];
            end
        end
    end
endmodule

// ### dv/swd_mcu_model.sv
// Processor model that kicks the watchdog while both resets are released.
`timescale 1ns/1ns
module swd_mcu_model (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Reset pins seen by the processor, kick period in cycles, 0 = none.
    input  wire logic        hv_rst_n,
    input  wire logic        lv_rst_n,
    input  wire logic [15:0] gap,
    // Kick output, idle high.
    output logic             kick
);
    logic [15:0] cnt_q;
    logic        run;

    // A processor held in reset cannot kick, so the count restarts.
    assign run = hv_rst_n && lv_rst_n && gap != 16'h0000;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 16'h0000;
        end else if (!run) begin
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= (cnt_q >= gap - 16'h0001) ? 16'h0000 : cnt_q + 16'h0001;
        end
    end

    // First fall comes half a period after start, then one per period.
    assign kick = !run || cnt_q < (gap >> 1);
endmodule

// ### dv/tb_swd_top.sv
// Self-checking bench for the supervisor, reset and watchdog block.
`timescale 1ns/1ns
module tb_swd_top;
    import swd_pkg::*;
`define CK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
    localparam int P = 20, D = 40, L = 10, U = 80;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic        chip_en, main_ok, ov, hv_fb, lv_fb, lv_start, lv_stop;
    logic        lv_en, wd_en, kick, hv_ss_low, lv_ss_low, ext, osc;
    logic        hv_oe, lv_oe, wdf_oe, pg_oe, hv_o, lv_o, wdf_o, pg_o;
    logic        hv_sw, lv_sw, hv_dis, lv_dis;
    logic [15:0] gap;
    int          miscompares, n_tests, n, np;
    int          regs [4] = '{P, D, L, U};
    // Row: ov, hv_fb, lv_en, lv_start, lv_fb -> hv_sw, lv_sw, pg_oe.
    logic [7:0]  rows [6] = '{8'h7F, 8'h3C, 8'h5C, 8'h6D, 8'h76, 8'hF0};
    // Open-drain pins with pull-ups.
    wire         hv_pin  = hv_oe ? hv_o : 1'b1;
    wire         lv_pin  = lv_oe ? lv_o : 1'b1;
    wire         wdf_pin = wdf_oe ? wdf_o : 1'b1;

    swd_top #(.RST_CYC(P), .DLY_CYC(D), .WDL_CYC(L), .WDU_CYC(U)) dut (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chip_enable_lockout(chip_en),
        .main_supply_ok(main_ok), .overvoltage_lockout(ov),
        .hv_feedback(hv_fb), .lv_feedback(lv_fb),
        .lv_supply_above_start(lv_start), .lv_supply_above_stop(lv_stop),
        .lv_channel_enable(lv_en), .watchdog_enable(wd_en),
        .watchdog_kick(kick), .hv_softstart_low(hv_ss_low),
        .lv_softstart_low(lv_ss_low), .external_clock_in(ext),
        .hv_reset_n_in(hv_pin), .hv_reset_n_o(hv_o), .hv_reset_n_oe(hv_oe),
        .lv_reset_n_in(lv_pin), .lv_reset_n_o(lv_o), .lv_reset_n_oe(lv_oe),
        .watchdog_fault_n_in(wdf_pin), .watchdog_fault_n_o(wdf_o),
        .watchdog_fault_n_oe(wdf_oe), .power_good_n_o(pg_o),
        .power_good_n_oe(pg_oe), .hv_switch_enable(hv_sw),
        .lv_switch_enable(lv_sw), .hv_softstart_discharge(hv_dis),
        .lv_softstart_discharge(lv_dis), .osc_restart(osc));

    swd_mcu_model mcu (.clk(clk), .rst_n(rst_n), .hv_rst_n(hv_pin),
        .lv_rst_n(lv_pin), .gap(gap), .kick(kick));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) if (osc !== 1'b0) np <= np + 1;

    task cyc(input int k);
        repeat (k) @(posedge clk);
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) miscompares++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Counts cycles until the signal takes the value, bounded.
    task automatic wt(ref logic s, input logic v);
        n = 0;
        while (s !== v && n < 3000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 3000) miscompares++;
    endtask

    task ext4;
        repeat (4) begin
            ext <= 1'b1;
            cyc(4);
            ext <= 1'b0;
            cyc(4);
        end
    endtask

    task close_out;
        $display("counts: tests=%0d mismatches=%0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #(20 * 30000);
        miscompares++;
        close_out;
    end

    initial begin
        rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        chip_en = 1; main_ok = 1; ov = 0; hv_fb = 0; lv_fb = 0; lv_en = 1;
        lv_start = 1; lv_stop = 1; wd_en = 1; hv_ss_low = 1; lv_ss_low = 1;
        ext = 0; gap = 16'h0004; miscompares = 0; n_tests = 0;
        cyc(3);
        rst_n <= 1'b1;
        cyc(8);
        `CK({hv_oe, lv_oe, wdf_oe, hv_pin}, 4'hC)
        `CK({hv_o, lv_o, wdf_o, pg_o}, 4'h0)
        // A value off the default proves the write lands; then restore.
        foreach (regs[i]) begin
            apb(1'b1, 8'(4 * i), 32'(regs[i] + 256));
            apb(1'b0, 8'(4 * i), 32'h0);
            `CK(r, 32'(regs[i] + 256))
            apb(1'b1, 8'(4 * i), 32'(regs[i]));
        end
        apb(1'b0, 8'h14, 32'h0);
        `CK({e, r}, 33'h1_0000_0000)
        $display("test reset and registers done");
        hv_fb <= 1'b1;
        wt(hv_oe, 1'b0);
        `CK(n >= P && n <= P + 10, 1'b1)
        lv_fb <= 1'b1;
        wt(lv_oe, 1'b0);
        `CK(n >= P && n <= P + 10, 1'b1)
        wt(wdf_oe, 1'b1);
        `CK(n >= D && n <= D + 20, 1'b1)
        gap <= 16'h0000;
        wt(wdf_oe, 1'b0);
        `CK(n >= P - 2 && n <= P + 2, 1'b1)
        cyc(D + 2);
        gap <= 16'd40;
        n = 0;
        repeat (400) begin
            @(posedge clk);
            n += int'(wdf_oe !== 1'b0);
        end
        `CK(n, 0)
        apb(1'b0, OFF_STATUS, 32'h0);
        `CK({r[4:3], r[1:0]}, {WD_WATCH, 2'h3})
        `CK(r[12:5], 8'hE7)
        gap <= 16'h0000;
        wt(wdf_oe, 1'b1);
        `CK(n <= U + 10, 1'b1)
        wd_en <= 1'b0;
        wt(wdf_oe, 1'b0);
        `CK(n <= 8, 1'b1)
        $display("test channels and watchdog done");
        foreach (rows[i]) begin
            {ov, hv_fb, lv_en, lv_start, lv_fb} <= rows[i][7:3];
            cyc(10);
            `CK({hv_sw, lv_sw, pg_oe}, rows[i][2:0])
        end
        ov <= 1'b0;
        hv_ss_low <= 1'b0;
        main_ok <= 1'b0;
        cyc(10);
        main_ok <= 1'b1;
        cyc(10);
        `CK(hv_dis, 1'b1)
        hv_ss_low <= 1'b1;
        cyc(10);
        `CK(hv_dis, 1'b0)
        lv_ss_low <= 1'b0;
        lv_stop <= 1'b0;
        cyc(10);
        lv_stop <= 1'b1;
        cyc(10);
        `CK(lv_dis, 1'b1)
        lv_ss_low <= 1'b1;
        cyc(10);
        `CK(lv_dis, 1'b0)
        chip_en <= 1'b0;
        cyc(10);
        `CK({hv_oe, lv_oe}, 2'b00)
        chip_en <= 1'b1;
        cyc(10);
        `CK({hv_oe, lv_oe}, 2'b11)
        $display("test gating and soft-start done");
        hv_fb <= 1'b0;
        cyc(10);
        n = np;
        ext4;
        `CK(np - n, 0)
        hv_fb <= 1'b1;
        cyc(10);
        n = np;
        ext4;
        `CK(np - n, 4)
        $display("test external clock done");
        close_out;
    end
endmodule
